// *** rtl/mesc_pkg.sv ***
// shared constants and types for the excitation and stop control block
package mesc_pkg;

    // register map, byte addresses on the lite bus
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SEL_LSB = 2;
    localparam int CTRL_MAPD_BIT = 4;
    localparam int CTRL_MAPR_BIT = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h1c;

    // stop action select: bit set means deceleration stop, except in pulse mode
    localparam int SEL_STOP_DECEL_BIT = 0;
    localparam int SEL_COFF_DECEL_BIT = 1;
    localparam logic [1:0] SEL_RST = 2'h3;

    // status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_DRIVE_LSB = 4;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // operation types
    typedef enum logic [1:0] {
        MODE_PULSE = 2'b00,
        MODE_STORED = 2'b01,
        MODE_MACRO = 2'b10,
        MODE_DIRECT = 2'b11
    } mesc_mode_e;

    // host control inputs, straight from the terminals
    typedef struct packed {
        logic free_input;
        logic excite_req_direct;
        logic excite_req_remote;
        logic deviation_clear_input;
        logic stop_deenergize_input;
        logic stop_input;
    } mesc_pins_s;

    localparam int PINS_W = 6;

    // drive outputs toward the power stage, profile and host
    typedef struct packed {
        logic pulse_accept_ready_output;
        logic ready_output;
        logic excite_on;
        logic brake_release;
        logic dyn_brake;
        logic pulse_in_disable;
        logic immed_stop;
        logic decel_stop;
        logic travel_clear;
        logic dev_clear;
        logic cmd_pos_latch;
        logic in_pos_inhibit;
    } mesc_drive_s;

    localparam int DRIVE_W = 12;

endpackage

// *** rtl/mesc_sync.sv ***
// two-flop synchroniser for the host control terminals
`timescale 1ns/10ps
module mesc_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] d_sync
);

    // one synchroniser pair per terminal
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_r;
        logic sync_r;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_r <= 1'b0;
                sync_r <= 1'b0;
            end else begin
                meta_r <= d_async[i];
                sync_r <= meta_r;
            end
        end
        assign d_sync[i] = sync_r;
    end

endmodule

// *** rtl/mesc_ctrl.sv ***
// excitation and stop control with a lite register slave
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module mesc_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire mesc_pkg::mesc_pins_s pins_async,
    input wire logic motor_moving,
    input wire logic excite_settled,
    output mesc_pkg::mesc_drive_s drive,
    input wire logic [mesc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mesc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import mesc_pkg::*;

    // control sequence states
    typedef enum logic [3:0] {
        ST_OFF = 4'b0000,
        ST_EXCITING = 4'b0001,
        ST_RUN = 4'b0010,
        ST_DROP = 4'b0011,
        ST_DECEL = 4'b0100,
        ST_HALT = 4'b0101,
        ST_COFF = 4'b0110,
        ST_CLR = 4'b0111
    } mesc_fsm_e;

    // whole module state
    typedef struct packed {
        mesc_fsm_e st;
        logic coff_pend;
        mesc_drive_s drv;
        logic [CTRL_W-1:0] ctrl;
        logic awready;
        logic wready;
        logic aw_hold;
        logic w_hold;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mesc_state_s;

    mesc_state_s s_r;
    mesc_state_s s_nxt;
    logic [PINS_W-1:0] pins_sync;
    mesc_pins_s pins;
    mesc_mode_e mode;
    logic [1:0] stop_action_select;
    logic map_direct;
    logic map_remote;
    logic creq_eff;
    logic pulse_mode;
    logic stp_decel;
    logic coff_decel;
    logic lose_excite;

    // terminal inputs cross into the control clock
    mesc_sync #(
        .W(PINS_W)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d_async(pins_async),
        .d_sync(pins_sync)
    );

    assign pins = pins_sync;

    // control register fields
    assign mode = mesc_mode_e'(s_r.ctrl[CTRL_MODE_LSB +: 2]);
    assign stop_action_select = s_r.ctrl[CTRL_SEL_LSB +: 2];
    assign map_direct = s_r.ctrl[CTRL_MAPD_BIT];
    assign map_remote = s_r.ctrl[CTRL_MAPR_BIT];
    assign pulse_mode = (mode == MODE_PULSE);

    // effective excitation request from terminal mapping
    always_comb begin
        creq_eff = 1'b1;
        if (map_direct && map_remote) begin
            creq_eff = pins.excite_req_direct && pins.excite_req_remote;
        end else if (map_direct) begin
            creq_eff = pins.excite_req_direct;
        end else if (map_remote) begin
            creq_eff = pins.excite_req_remote;
        end
    end

    assign stp_decel = !pulse_mode && stop_action_select[SEL_STOP_DECEL_BIT];
    assign coff_decel = !pulse_mode && stop_action_select[SEL_COFF_DECEL_BIT];
    assign lose_excite = pins.free_input || !creq_eff;

    // next state: sequence, outputs and bus slave
    always_comb begin
        s_nxt = s_r;
        s_nxt.drv.immed_stop = 1'b0;
        s_nxt.drv.travel_clear = 1'b0;
        s_nxt.drv.cmd_pos_latch = 1'b0;

        unique case (s_r.st)
            ST_OFF: begin
                if (creq_eff && !pins.free_input &&
                    !pins.stop_deenergize_input) begin
                    s_nxt.st = ST_EXCITING;
                end
            end
            ST_EXCITING: begin
                if (lose_excite) begin
                    s_nxt.st = ST_OFF;
                end else if (excite_settled) begin
                    s_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (lose_excite) begin
                    s_nxt.st = ST_DROP;
                end else if (pins.stop_deenergize_input) begin
                    if (coff_decel) begin
                        s_nxt.st = ST_DECEL;
                        s_nxt.coff_pend = 1'b1;
                    end else begin
                        s_nxt.st = ST_COFF;
                        s_nxt.drv.immed_stop = 1'b1;
                        s_nxt.drv.cmd_pos_latch = 1'b1;
                        s_nxt.drv.travel_clear = !pulse_mode;
                    end
                end else if (pins.deviation_clear_input) begin
                    s_nxt.st = ST_CLR;
                    s_nxt.drv.immed_stop = 1'b1;
                    s_nxt.drv.travel_clear = !pulse_mode;
                end else if (pins.stop_input) begin
                    s_nxt.coff_pend = 1'b0;
                    if (stp_decel) begin
                        s_nxt.st = ST_DECEL;
                    end else begin
                        s_nxt.st = ST_HALT;
                        s_nxt.drv.immed_stop = 1'b1;
                        s_nxt.drv.cmd_pos_latch = 1'b1;
                        s_nxt.drv.travel_clear = !pulse_mode;
                    end
                end
            end
            ST_DROP: begin
                s_nxt.st = ST_OFF;
            end
            ST_DECEL: begin
                if (lose_excite) begin
                    s_nxt.st = ST_DROP;
                end else if (!motor_moving) begin
                    s_nxt.drv.travel_clear = 1'b1;
                    if (s_r.coff_pend && pins.stop_deenergize_input) begin
                        s_nxt.st = ST_COFF;
                    end else if (!s_r.coff_pend && pins.stop_input) begin
                        s_nxt.st = ST_HALT;
                    end else begin
                        s_nxt.st = ST_RUN;
                    end
                    s_nxt.coff_pend = 1'b0;
                end
            end
            ST_HALT: begin
                if (lose_excite) begin
                    s_nxt.st = ST_DROP;
                end else if (pins.stop_deenergize_input) begin
                    s_nxt.st = ST_COFF;
                end else if (!pins.stop_input) begin
                    s_nxt.st = ST_RUN;
                end
            end
            ST_COFF: begin
                if (!creq_eff) begin
                    s_nxt.st = ST_OFF;
                end else if (!pins.stop_deenergize_input &&
                             !pins.free_input) begin
                    s_nxt.st = ST_EXCITING;
                end
            end
            ST_CLR: begin
                if (lose_excite) begin
                    s_nxt.st = ST_DROP;
                end else if (!pins.deviation_clear_input) begin
                    s_nxt.st = ST_RUN;
                end
            end
            default: begin
                s_nxt.st = ST_OFF;
            end
        endcase

        // level outputs follow the next state
        // readies only once excited and running
        s_nxt.drv.pulse_accept_ready_output = (s_nxt.st == ST_RUN);
        s_nxt.drv.ready_output = (s_nxt.st == ST_RUN);
        s_nxt.drv.excite_on = (s_nxt.st == ST_EXCITING) ||
                              (s_nxt.st == ST_RUN) ||
                              (s_nxt.st == ST_DROP) ||
                              (s_nxt.st == ST_DECEL) ||
                              (s_nxt.st == ST_HALT) ||
                              (s_nxt.st == ST_CLR);
        // brake freed once excitation settled, or when free is held while off
        s_nxt.drv.brake_release = (s_nxt.st == ST_RUN) ||
                                  (s_nxt.st == ST_DECEL) ||
                                  (s_nxt.st == ST_HALT) ||
                                  (s_nxt.st == ST_CLR) ||
                                  (((s_nxt.st == ST_OFF) ||
                                    (s_nxt.st == ST_COFF)) &&
                                   pins.free_input);
        s_nxt.drv.dyn_brake = (s_nxt.st == ST_OFF) && !creq_eff &&
                              !pins.free_input;
        // pulse input held off while stopped in pulse mode
        s_nxt.drv.pulse_in_disable = pulse_mode &&
                                     ((s_nxt.st == ST_HALT) ||
                                      (s_nxt.st == ST_COFF) ||
                                      (s_nxt.st == ST_CLR) ||
                                      (s_nxt.st == ST_DECEL));
        s_nxt.drv.decel_stop = (s_nxt.st == ST_DECEL);
        s_nxt.drv.dev_clear = (s_nxt.st == ST_CLR);
        s_nxt.drv.in_pos_inhibit = (s_nxt.st == ST_DECEL) ||
                                   (s_nxt.st == ST_HALT) ||
                                   (s_nxt.st == ST_COFF) ||
                                   (s_nxt.st == ST_CLR);

        // write address and data taken independently
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_hold = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
            s_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_hold = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
            s_nxt.wready = 1'b0;
        end

        // write commit once both halves are held
        if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
            s_nxt.aw_hold = 1'b0;
            s_nxt.w_hold = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_SLVERR;
            if (s_r.awaddr == REG_CTRL) begin
                s_nxt.bresp = RESP_OKAY;
                if (s_r.wstrb[0]) begin
                    s_nxt.ctrl = s_r.wdata[CTRL_W-1:0];
                end
            end
        end

        // write response handshake reopens both channels
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end

        // read address taken, data one cycle later
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.rresp = RESP_OKAY;
            if (s_axi_araddr == REG_CTRL) begin
                s_nxt.rdata[CTRL_W-1:0] = s_r.ctrl;
            end else if (s_axi_araddr == REG_STAT) begin
                s_nxt.rdata[STAT_STATE_LSB +: 4] = s_r.st;
                s_nxt.rdata[STAT_DRIVE_LSB +: DRIVE_W] = s_r.drv;
            end else begin
                s_nxt.rresp = RESP_SLVERR;
            end
        end

        // read data handshake
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign drive = s_r.drv;
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

endmodule

// *** tb/mesc_ctrl_asserts.sv ***
// port assertions for the excitation and stop control block
`timescale 1ns/10ps
module mesc_ctrl_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire mesc_pkg::mesc_pins_s pins_async,
    input wire logic excite_settled,
    input wire mesc_pkg::mesc_drive_s drive
);
    import mesc_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // free held: shaft loose, brake off, no coil short
    property p_free_off;
        pins_async.free_input [*5] |->
            !drive.excite_on && drive.brake_release && !drive.dyn_brake;
    endproperty
    a_free_off: assert property (p_free_off)
        else $error("free held but motor still held");
    // readies already low when free removes excitation
    property p_drop_first;
        $fell(drive.excite_on) && pins_async.free_input
            |-> !$past(drive.ready_output);
    endproperty
    a_drop_first: assert property (p_drop_first)
        else $error("excitation dropped before readies");
    // brake frees only once excitation settled
    property p_brake_late;
        $rose(drive.brake_release) && drive.excite_on
            |-> $past(excite_settled);
    endproperty
    a_brake_late: assert property (p_brake_late)
        else $error("brake freed before excitation settled");
    // ready only with motor excited
    property p_ready_exc;
        drive.ready_output |-> drive.excite_on && !drive.dyn_brake;
    endproperty
    a_ready_exc: assert property (p_ready_exc)
        else $error("ready without excitation");
    // both ready outputs rise together
    property p_both_ready;
        $rose(drive.ready_output) |-> drive.pulse_accept_ready_output;
    endproperty
    a_both_ready: assert property (p_both_ready)
        else $error("ready rose without pulse ready");
    // coil short only with excitation off, ready low and brake held
    property p_dyn;
        drive.dyn_brake |-> !drive.excite_on && !drive.brake_release
            && !drive.ready_output;
    endproperty
    a_dyn: assert property (p_dyn)
        else $error("coil short while excited or brake free");
    // any stop keeps in-position off
    property p_no_inpos;
        (drive.decel_stop || drive.immed_stop) |-> drive.in_pos_inhibit;
    endproperty
    a_no_inpos: assert property (p_no_inpos)
        else $error("stop without in-position inhibit");
    // immediate stop outside deviation clear latches command position, pulse ready off
    property p_imm;
        drive.immed_stop && !drive.dev_clear
            |-> drive.cmd_pos_latch && !drive.pulse_accept_ready_output;
    endproperty
    a_imm: assert property (p_imm)
        else $error("immediate stop without position latch");
    // deviation clear keeps pulse ready low
    property p_clr;
        drive.dev_clear |-> !drive.pulse_accept_ready_output;
    endproperty
    a_clr: assert property (p_clr)
        else $error("pulse ready during deviation clear");
    c_decel: cover property (drive.decel_stop);
    c_imm: cover property (drive.immed_stop);
    c_clr: cover property (drive.dev_clear);
endmodule

bind mesc_ctrl mesc_ctrl_asserts i_chk (.aclk, .aresetn, .pins_async,
    .excite_settled, .drive);

// *** tb/mesc_plant.sv ***
// power stage and motion profile model beside the control block
`timescale 1ns/10ps
module mesc_plant (
    input wire logic aclk,
    input wire logic aresetn,
    input wire mesc_pkg::mesc_drive_s drive,
    input wire logic go,
    input wire logic slow,
    input wire logic [7:0] dec_len,
    output logic motor_moving,
    output logic excite_settled
);
    import mesc_pkg::*;
    logic [7:0] set_cnt;
    logic [7:0] dec_cnt;
    // settle after excitation, slow or prompt; motion ends on halts
    always_ff @(posedge aclk) begin
        if (!aresetn || !drive.excite_on) begin
            set_cnt <= 8'h0;
            excite_settled <= 1'b0;
        end else begin
            if (set_cnt != 8'hff) set_cnt <= set_cnt + 8'h1;
            excite_settled <= set_cnt >= (slow ? 8'h8 : 8'h1);
        end
        if (!aresetn || !drive.excite_on || drive.immed_stop
            || drive.dev_clear) begin
            motor_moving <= 1'b0;
            dec_cnt <= 8'h0;
        end else if (go) begin
            motor_moving <= 1'b1;
        end else if (drive.decel_stop && motor_moving) begin
            dec_cnt <= dec_cnt + 8'h1;
            if (dec_cnt >= dec_len) motor_moving <= 1'b0;
        end else begin
            dec_cnt <= 8'h0;
        end
    end
endmodule

// *** tb/motor_excitation_stop_control_test.sv ***
// self-checking bench for the excitation and stop control block
`timescale 1ns/10ps
module motor_excitation_stop_control_test;
    import mesc_pkg::*;
    logic aclk = 0, aresetn = 0, go = 0, slow = 0, exc_d = 0;
    logic [7:0] dec_len = 8'h4;
    mesc_pins_s pins_async = '0;
    mesc_drive_s drive;
    logic motor_moving, excite_settled;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors = 0, num_checks = 0, n_imm = 0, n_tc = 0, n_xf = 0;

    always #5 aclk = ~aclk;

    mesc_ctrl i_dut (.aclk, .aresetn, .pins_async, .motor_moving,
        .excite_settled, .drive, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    mesc_plant i_plant (.aclk, .aresetn, .drive, .go, .slow, .dec_len,
        .motor_moving, .excite_settled);

    // tallies of one-cycle pulses and excitation drops
    always @(posedge aclk) begin
        n_imm <= n_imm + int'(drive.immed_stop === 1'b1);
        n_tc <= n_tc + int'(drive.travel_clear === 1'b1);
        exc_d <= drive.excite_on;
        if (exc_d === 1'b1 && drive.excite_on === 1'b0) n_xf <= n_xf + 1;
    end

    task end_sim;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task tmo(inout int n);
        n++;
        if (n > 400) begin
            num_errors++;
            $display("unexpected hang expected answer seen none");
            end_sim;
        end
    endtask

    function logic sig(input int k);
        case (k)
            0: return drive.ready_output;
            1: return drive.excite_on;
            2: return motor_moving;
            default: return drive.brake_release;
        endcase
    endfunction

    task wt(input int k, input logic v);
        int n;
        n = 0;
        while (sig(k) !== v) begin
            @(posedge aclk);
            tmo(n);
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            tmo(n);
        end
        s_axi_bready <= 0;
        chk("bresp", r, s_axi_bresp);
    endtask

    task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            tmo(n);
        end
        s_axi_rready <= 0;
        chk("rdata", d, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
    endtask

    // start a move and wait until the motor is moving
    task move;
        go <= 1;
        @(posedge aclk);
        go <= 0;
        wt(2, 1);
    endtask

    initial begin
        logic [1:0] m;
        logic [1:0] s;
        logic im;
        int k, ti, tt, tx;
        void'($urandom(13265));
        repeat (4) @(posedge aclk);
        chk("rst_drive", 32'h0, {20'h0, drive});
        aresetn <= 1;
        rd(REG_CTRL, 32'h1c, RESP_OKAY);
        wr(REG_STAT, 32'h0, RESP_SLVERR);
        rd(4'h8, 32'h0, RESP_SLVERR);
        pins_async.excite_req_direct <= 1;
        wt(0, 1);
        chk("brake", 1, drive.brake_release);
        pins_async.free_input <= 1;
        wt(1, 0);
        chk("free_brk", 1, drive.brake_release);
        chk("free_rdy", 0, drive.ready_output);
        repeat (3) @(posedge aclk);
        pins_async.free_input <= 0;
        wt(0, 1);
        pins_async.excite_req_direct <= 0;
        wt(1, 0);
        chk("dyn", 1, drive.dyn_brake);
        chk("hold", 0, drive.brake_release);
        pins_async.free_input <= 1;
        wt(3, 1);
        repeat (3) @(posedge aclk);
        pins_async.free_input <= 0;
        wt(3, 0);
        wr(REG_CTRL, 32'h0d, RESP_OKAY);
        wt(0, 1);
        wr(REG_CTRL, 32'h3d, RESP_OKAY);
        wt(1, 0);
        pins_async.excite_req_direct <= 1;
        repeat (6) @(posedge aclk);
        chk("and", 0, drive.excite_on);
        pins_async.excite_req_remote <= 1;
        wt(0, 1);
        rd(REG_CTRL, 32'h3d, RESP_OKAY);
        // running, stored mode: readies, excitation, brake free
        rd(REG_STAT, 32'h0000_f002, RESP_OKAY);
        // each stop kind against each select value
        for (int i = 0; i < 12; i++) begin
            k = i % 3;
            s = 2'(i % 4);
            m = i < 4 ? 2'(i) : 2'($urandom);
            dec_len <= 8'($urandom % 30);
            slow <= 1'($urandom);
            wr(REG_CTRL, {26'h0, 2'b11, s, m}, RESP_OKAY);
            move;
            ti = n_imm;
            tt = n_tc;
            case (k)
                0: pins_async.stop_deenergize_input <= 1;
                1: pins_async.stop_input <= 1;
                default: pins_async.deviation_clear_input <= 1;
            endcase
            im = m == MODE_PULSE || k == 2 || !s[k == 0];
            wt(0, 0);
            chk("inpos", 1, drive.in_pos_inhibit);
            chk("pulse_accept_ready_output", 0, drive.pulse_accept_ready_output);
            if (!im) chk("decel", 1, drive.decel_stop);
            if (m == MODE_PULSE)
                chk("pdis", 1, drive.pulse_in_disable);
            if (k == 2) chk("dclr", 1, drive.dev_clear);
            wt(2, 0);
            if (k == 0) wt(1, 0);
            pins_async.stop_deenergize_input <= 0;
            pins_async.stop_input <= 0;
            pins_async.deviation_clear_input <= 0;
            wt(0, 1);
            chk("exc", 1, drive.excite_on);
            if (im && k != 2) chk("imm", ti + 1, n_imm);
            chk("trav", tt + int'(m != MODE_PULSE), n_tc);
        end
        wr(REG_CTRL, 32'h3d, RESP_OKAY);
        dec_len <= 8'h28;
        move;
        tx = n_xf;
        pins_async.stop_deenergize_input <= 1;
        wt(0, 0);
        pins_async.stop_deenergize_input <= 0;
        wt(2, 0);
        wt(0, 1);
        chk("stay", tx, n_xf);
        // mid-run reset restores defaults, then re-excites
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        chk("rst_drive2", 32'h0, {20'h0, drive});
        aresetn <= 1;
        rd(REG_CTRL, {26'h0, CTRL_RST}, RESP_OKAY);
        wt(0, 1);
        end_sim;
    end
endmodule
